// >>> pkg/vci_pkg.sv
// Constants, types and access encodings for the virtual interface
// control and type register block.
// Assumes a core that presents one decoded system-register access per cycle.
package vci_pkg;
  localparam logic [1:0]  ENC_OP0    = 2'h3;
  localparam logic [2:0]  ENC_OP1    = 3'h4;
  localparam logic [3:0]  ENC_CRN    = 4'hc;
  localparam logic [3:0]  ENC_CRM    = 4'hb;
  localparam logic [2:0]  OP2_CTRL   = 3'h7;
  localparam logic [2:0]  OP2_TYPE   = 3'h1;
  localparam int          PAGE_SHIFT = 12;
  localparam logic [63:0] CTRL_MEM_OFS = 64'h4c8;
  localparam int          GRP0_EN_BIT  = 0;
  localparam int          BPR0_LSB     = 21;
  localparam int          PRIO_LSB   = 29;
  localparam int          PRE_LSB    = 26;
  localparam int          ID_LSB     = 23;
  localparam int          SERR_BIT   = 22;
  localparam int          AFF3_BIT   = 21;
  localparam int          NOINJ_BIT  = 20;
  localparam int          DTRAP_BIT  = 19;
  localparam int          LR_LSB     = 0;
  localparam logic [2:0]  ID_16      = 3'h0;
  localparam logic [2:0]  ID_24      = 3'h1;
  localparam logic [2:0]  PRE_MIN_M1 = 3'h4;
  localparam logic [2:0]  PRE_MAX_M1 = 3'h6;
  localparam logic [2:0]  BPR_MAX    = 3'h7;
  localparam logic [63:0] CTRL_WMASK = 64'h0000_0000_ffe0_021f;
  localparam logic [1:0]  EL1 = 2'h1;
  localparam logic [1:0]  EL2 = 2'h2;
  localparam logic [1:0]  EL3 = 2'h3;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  el;
    logic [1:0]  op0;
    logic [2:0]  op1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  op2;
    logic [63:0] wdata;
  } vci_req_s;

  typedef struct packed {
    logic        sysreg_enable_hyp;
    logic        sysreg_enable_monitor;
    logic        nested_virt_ctrl;
    logic        nested_virt_mem_redirect;
    logic        host_trap_general;
    logic        nonsecure_state;
    logic        secure_hyp_enable;
    logic        hyp_is_64bit;
    logic [51:0] nested_ctx_base;
  } vci_cfg_s;

  typedef struct packed {
    logic        done;
    logic        trap_el2;
    logic        trap_el3;
    logic        undef;
    logic        mem_redirect;
    logic [63:0] mem_addr;
    logic [63:0] rdata;
  } vci_rsp_s;
endpackage

// >>> test/vci_core_model.sv
// Core model: issues one system-register access per call.
// Assumes calls are made at falling edges of clk_sys.
`timescale 1ns/10ps
`default_nettype none
module vci_core_model (
  input  wire logic         clk_sys,
  output vci_pkg::vci_req_s req,
  output vci_pkg::vci_cfg_s cfg
);
  // ----------
  // Requests
  // ----------
  initial begin
    req = '0;
    cfg = '0;
  end
  task automatic acc(input logic w, input logic [1:0] el, input logic [2:0] op2,
                     input logic [3:0] crm, input logic [63:0] wd,
                     input vci_pkg::vci_cfg_s c);
    req.valid = 1'b1;
    req.write = w;
    req.el = el;
    req.op0 = vci_pkg::ENC_OP0;
    req.op1 = vci_pkg::ENC_OP1;
    req.crn = vci_pkg::ENC_CRN;
    req.crm = crm;
    req.op2 = op2;
    req.wdata = wd;
    cfg = c;
    @(negedge clk_sys);
  endtask
  // Released data toggles so a stale word never looks valid
  task automatic idle(input int n);
    req.valid = 1'b0;
    req.wdata = ~req.wdata;
    repeat (n) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> test/virtual_cpu_if_ctrl_type_regs_tb.sv
// Bench: drives accesses through the core model, queues expected answers.
// Assumes the register block answers each taken access with one done.
`timescale 1ns/10ps
`default_nettype none
module virtual_cpu_if_ctrl_type_regs_tb;
  localparam logic [2:0] PRE = 3'h4;
  localparam logic [2:0] BPMIN = 3'h7 - PRE;
  logic              clk_sys = 1'b0;
  logic              srst = 1'b1;
  vci_pkg::vci_req_s req;
  vci_pkg::vci_cfg_s cfg;
  vci_pkg::vci_cfg_s c;
  vci_pkg::vci_rsp_s rsp;
  vci_pkg::vci_rsp_s e;
  vci_pkg::vci_rsp_s eq[$];
  logic [1:0]        fq[$];
  logic [1:0]        f;
  logic              en;
  logic [2:0]        bp;
  logic [63:0]       wd;
  logic [63:0]       ex;
  logic [63:0]       tw;
  int                error_cnt = 0;
  int                checks = 0;
  int                cyc = 0;
  int unsigned       r;

  vci_core_model core (.clk_sys(clk_sys), .req(req), .cfg(cfg));
  vci_regs #(.PRIO_BITS_M1(3'h5), .PREEMPT_M1(PRE), .ID_CODE(vci_pkg::ID_24),
    .SERR_SUPPORT(1'b1), .AFF3_SUPPORT(1'b1), .DIRECT_INJECT(1'b1)) DUT (
    .clk_sys(clk_sys), .srst(srst), .req(req), .cfg(cfg), .rsp(rsp),
    .virt_grp0_enable(en), .virt_grp0_binary_point(bp));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk64(input string n, input logic [63:0] x, input logic [63:0] g);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // f[0] compares read data, f[1] the group 0 outputs
  task automatic go(input logic w, input logic [1:0] el, input logic [2:0] op2,
                    input logic [3:0] fl, input logic [63:0] ea,
                    input logic [63:0] ed, input logic [1:0] ff);
    vci_pkg::vci_rsp_s x;
    x = '0;
    x.done = 1'b1;
    {x.trap_el2, x.trap_el3, x.undef, x.mem_redirect} = fl;
    x.mem_addr = ea;
    x.rdata = ed;
    eq.push_back(x);
    fq.push_back(ff);
    core.acc(w, el, op2, vci_pkg::ENC_CRM, wd, c);
  endtask

  // ----------
  // Answer monitor
  // ----------
  always @(negedge clk_sys) begin
    if (!srst && rsp.done === 1'b1) begin
      if (eq.size() == 0) chk64("spurious done", 64'h0, 64'h1);
      else begin
        e = eq.pop_front();
        f = fq.pop_front();
        chk64("flags", {60'h0, e.trap_el2, e.trap_el3, e.undef, e.mem_redirect},
          {60'h0, rsp.trap_el2, rsp.trap_el3, rsp.undef, rsp.mem_redirect});
        if (e.mem_redirect) chk64("mem_addr", e.mem_addr, rsp.mem_addr);
        if (f[0]) chk64("rdata", e.rdata, rsp.rdata);
        if (f[1]) chk64("grp0", {60'h0, e.rdata[23:21], e.rdata[0]}, {60'h0, bp, en});
      end
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    r = $urandom(71);
    c = '0;
    wd = '0;
    tw = '0;
    tw[vci_pkg::PRIO_LSB +: 3] = 3'h5;
    tw[vci_pkg::PRE_LSB +: 3] = PRE;
    tw[vci_pkg::ID_LSB +: 3] = vci_pkg::ID_24;
    tw[vci_pkg::SERR_BIT] = 1'b1;
    tw[vci_pkg::AFF3_BIT] = 1'b1;
    tw[vci_pkg::DTRAP_BIT] = 1'b1;
    tw[4:0] = 5'h0f;
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    chk64("reset", 64'h0, {62'h0, rsp.done, en});
    {c.sysreg_enable_hyp, c.sysreg_enable_monitor, c.nonsecure_state} = 3'h7;
    c.hyp_is_64bit = 1'b1;
    // Back-to-back write and read, binary point at and below its floor
    for (int i = 0; i < 8; i++) begin
      wd = {$urandom, $urandom};
      if (i < 2) wd[23:21] = BPMIN - 3'(1 - i);
      ex = wd & vci_pkg::CTRL_WMASK;
      if (ex[23:21] < BPMIN) ex[23:21] = BPMIN;
      go(1'b1, vci_pkg::EL3, vci_pkg::OP2_CTRL, 4'h0, 64'h0, ex, 2'b10);
      wd = ~wd;
      go(1'b0, i[0] ? vci_pkg::EL3 : vci_pkg::EL2, vci_pkg::OP2_CTRL, 4'h0, 64'h0, ex,
        2'b11);
    end
    $display("test control done");
    go(1'b0, vci_pkg::EL2, vci_pkg::OP2_TYPE, 4'h0, 64'h0, tw, 2'b01);
    go(1'b1, vci_pkg::EL3, vci_pkg::OP2_TYPE, 4'h2, 64'h0, 64'h0, 2'b00);
    go(1'b0, vci_pkg::EL3, vci_pkg::OP2_TYPE, 4'h0, 64'h0, tw, 2'b01);
    $display("test type done");
    c.sysreg_enable_hyp = 1'b0;
    go(1'b0, vci_pkg::EL2, vci_pkg::OP2_TYPE, 4'h8, 64'h0, 64'h0, 2'b00);
    go(1'b1, vci_pkg::EL2, vci_pkg::OP2_CTRL, 4'h8, 64'h0, 64'h0, 2'b00);
    {c.sysreg_enable_hyp, c.sysreg_enable_monitor} = 2'b10;
    go(1'b0, vci_pkg::EL3, vci_pkg::OP2_CTRL, 4'h4, 64'h0, 64'h0, 2'b00);
    c.sysreg_enable_monitor = 1'b1;
    $display("test traps done");
    {c.nested_virt_ctrl, c.nested_virt_mem_redirect} = 2'b11;
    for (int i = 0; i < 3; i++) begin
      ex = {$urandom, $urandom};
      c.nested_ctx_base = ex[51:0];
      ex = {ex[51:0], 12'h0} + vci_pkg::CTRL_MEM_OFS;
      go(i[0], vci_pkg::EL1, vci_pkg::OP2_CTRL, 4'h1, ex, 64'h0, 2'b00);
    end
    c.nested_virt_mem_redirect = 1'b0;
    go(1'b0, vci_pkg::EL1, vci_pkg::OP2_CTRL, 4'h8, 64'h0, 64'h0, 2'b00);
    c.nonsecure_state = 1'b0;
    go(1'b0, vci_pkg::EL1, vci_pkg::OP2_CTRL, 4'h2, 64'h0, 64'h0, 2'b00);
    $display("test el1 done");
    core.acc(1'b1, vci_pkg::EL3, vci_pkg::OP2_CTRL, 4'ha, wd, c);
    core.idle(4);
    chk64("pending", 64'h0, 64'(eq.size()));
    $display("test decode done");
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> verilog/vci_regs.sv
// Virtual machine control and virtual type registers of the virtual
// interrupt CPU interface. One access in, one registered response out.
// Assumes req and cfg are synchronous to clk_sys from the core.
`timescale 1ns/10ps
`default_nettype none
module vci_regs #(
  parameter bit         HYP_IMPL       = 1'b1,
  parameter logic [2:0] PRIO_BITS_M1   = 3'h4,
  parameter logic [2:0] PREEMPT_M1     = 3'h4,
  parameter logic [2:0] ID_CODE        = 3'h0,
  parameter bit         SERR_SUPPORT   = 1'b0,
  parameter bit         AFF3_SUPPORT   = 1'b0,
  parameter bit         DIRECT_INJECT  = 1'b0,
  parameter bit         DTRAP_SUPPORT  = 1'b1,
  parameter logic [4:0] LIST_REGS_M1   = 5'h0f
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire vci_pkg::vci_req_s req,
  input  wire vci_pkg::vci_cfg_s cfg,
  output vci_pkg::vci_rsp_s      rsp,
  output logic                   virt_grp0_enable,
  output logic [2:0]             virt_grp0_binary_point
);
  // ------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------
  function automatic logic hits(input vci_pkg::vci_req_s r, input logic [2:0] op2);
    hits = r.valid && r.op0 == vci_pkg::ENC_OP0 && r.op1 == vci_pkg::ENC_OP1 &&
           r.crn == vci_pkg::ENC_CRN && r.crm == vci_pkg::ENC_CRM && r.op2 == op2;
  endfunction

  // type word built once from constants
  function automatic logic [63:0] type_word();
    logic [63:0] w;
    w = '0;
    w[vci_pkg::PRIO_LSB +: 3] = PRIO_BITS_M1;
    w[vci_pkg::PRE_LSB +: 3]  = PREEMPT_M1;
    w[vci_pkg::ID_LSB +: 3]   = ID_CODE;
    w[vci_pkg::SERR_BIT]      = SERR_SUPPORT;
    w[vci_pkg::AFF3_BIT]      = AFF3_SUPPORT;
    w[vci_pkg::NOINJ_BIT]     = ~DIRECT_INJECT;
    w[vci_pkg::DTRAP_BIT]     = DTRAP_SUPPORT;
    w[vci_pkg::LR_LSB +: 5]   = LIST_REGS_M1;
    // no EL2: all zero except no-inject
    if (!HYP_IMPL) begin
      w = '0;
      w[vci_pkg::NOINJ_BIT] = 1'b1;
    end
    type_word = w;
  endfunction

  localparam logic [63:0] TYPE_VALUE = type_word();

  logic [63:0]        ctrl;
  logic [63:0]        next_ctrl;
  vci_pkg::vci_rsp_s  next_rsp;
  logic               hit_ctrl;
  logic               hit_type;
  logic               sec_ok;
  logic [2:0]         wbpr;

  // ------------------------------------------------------------------
  // Access resolution
  // ------------------------------------------------------------------
  always_comb begin
    hit_ctrl  = hits(req, vci_pkg::OP2_CTRL);
    hit_type  = hits(req, vci_pkg::OP2_TYPE);
    sec_ok    = cfg.nonsecure_state || cfg.secure_hyp_enable;
    next_ctrl = ctrl;
    next_rsp  = '0;
    wbpr      = req.wdata[vci_pkg::BPR0_LSB +: 3];
    next_rsp.done = hit_ctrl || hit_type;
    if (hit_ctrl || hit_type) begin
      if (hit_type && req.write) begin
        // writes to read-only type register are undefined
        next_rsp.undef = 1'b1;
      end else if (req.el == vci_pkg::EL2 && !cfg.sysreg_enable_hyp) begin
        next_rsp.trap_el2 = 1'b1;
      end else if (req.el == vci_pkg::EL3 && !cfg.sysreg_enable_monitor) begin
        next_rsp.trap_el3 = 1'b1;
      end else if (req.el == vci_pkg::EL1 && hit_ctrl && sec_ok &&
                   cfg.nested_virt_ctrl && cfg.nested_virt_mem_redirect &&
                   !cfg.host_trap_general) begin
        next_rsp.mem_redirect = 1'b1;
        next_rsp.mem_addr = ({12'h000, cfg.nested_ctx_base} << vci_pkg::PAGE_SHIFT) +
                            vci_pkg::CTRL_MEM_OFS;
      end else if (req.el == vci_pkg::EL1 && hit_ctrl && sec_ok &&
                   cfg.nested_virt_ctrl && !cfg.nested_virt_mem_redirect &&
                   cfg.hyp_is_64bit) begin
        next_rsp.trap_el2 = 1'b1;
      end else if (req.el == vci_pkg::EL3 || req.el == vci_pkg::EL2 && sec_ok) begin
        if (hit_type) begin
          next_rsp.rdata = TYPE_VALUE;
        end else if (req.write) begin
          next_ctrl = req.wdata & vci_pkg::CTRL_WMASK;
          // binary point clamps to preemption-derived minimum
          if (wbpr < vci_pkg::BPR_MAX - PREEMPT_M1) begin
            next_ctrl[vci_pkg::BPR0_LSB +: 3] = vci_pkg::BPR_MAX - PREEMPT_M1;
          end
          if (!HYP_IMPL) begin
            next_ctrl = '0;
          end
        end else begin
          next_rsp.rdata = ctrl;
        end
      end else begin
        next_rsp.undef = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= '0;
      rsp  <= '0;
      virt_grp0_enable <= 1'b0;
      virt_grp0_binary_point <= 3'h0;
    end else begin
      ctrl <= next_ctrl;
      rsp  <= next_rsp;
      // group 0 enable from bit 0
      virt_grp0_enable <= next_ctrl[vci_pkg::GRP0_EN_BIT];
      virt_grp0_binary_point <= next_ctrl[vci_pkg::BPR0_LSB +: 3];
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  initial begin
    assert (PRIO_BITS_M1 >= vci_pkg::PRE_MIN_M1 && PREEMPT_M1 >= vci_pkg::PRE_MIN_M1 &&
            PREEMPT_M1 <= PRIO_BITS_M1 && PREEMPT_M1 <= vci_pkg::PRE_MAX_M1 &&
            (ID_CODE == vci_pkg::ID_16 || ID_CODE == vci_pkg::ID_24))
      else $error("bad type parameters");
  end

  trap_hyp_a: assert property (@(posedge clk_sys) disable iff (srst)
    hits(req, vci_pkg::OP2_CTRL) && req.el == vci_pkg::EL2 && !cfg.sysreg_enable_hyp
    |=> rsp.trap_el2 && rsp.rdata == '0 && $stable(ctrl))
    else $error("EL2 access not trapped");
  trap_mon_a: assert property (@(posedge clk_sys) disable iff (srst)
    hits(req, vci_pkg::OP2_TYPE) && req.el == vci_pkg::EL3 && !cfg.sysreg_enable_monitor
    && !req.write |=> rsp.trap_el3)
    else $error("EL3 type read not trapped");
  redirect_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
    rsp.mem_redirect |-> rsp.mem_addr[11:0] == vci_pkg::CTRL_MEM_OFS[11:0] && !rsp.trap_el2)
    else $error("redirect address wrong");
  nested_trap_a: assert property (@(posedge clk_sys) disable iff (srst)
    hits(req, vci_pkg::OP2_CTRL) && req.el == vci_pkg::EL1 && cfg.nested_virt_ctrl &&
    !cfg.nested_virt_mem_redirect && cfg.hyp_is_64bit && cfg.nonsecure_state
    |=> rsp.trap_el2)
    else $error("nested EL1 access not trapped");
  grp0_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
    virt_grp0_enable == ctrl[vci_pkg::GRP0_EN_BIT])
    else $error("group 0 enable mismatch");
  write_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    hits(req, vci_pkg::OP2_CTRL) && req.write && req.el == vci_pkg::EL3 &&
    cfg.sysreg_enable_monitor ##1 hits(req, vci_pkg::OP2_CTRL) && !req.write &&
    req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> rsp.rdata[0] == $past(req.wdata[0], 2) || !HYP_IMPL)
    else $error("control write not read back");
  bpr_floor_a: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(ctrl) |-> ctrl[vci_pkg::BPR0_LSB +: 3] >= vci_pkg::BPR_MAX - PREEMPT_M1
    || ctrl == '0)
    else $error("binary point below minimum");
  type_const_a: assert property (@(posedge clk_sys) disable iff (srst)
    rsp.done && hits($past(req), vci_pkg::OP2_TYPE) && rsp.rdata != '0
    |-> rsp.rdata == TYPE_VALUE && rsp.rdata[63:32] == '0 && rsp.rdata[18:5] == '0)
    else $error("type read value wrong");
  noinj_a: assert property (@(posedge clk_sys) disable iff (srst)
    rsp.rdata == TYPE_VALUE |-> rsp.rdata[vci_pkg::NOINJ_BIT] == ~DIRECT_INJECT)
    else $error("direct inject bit wrong");


  // ------------------------------------------------------------------
  // Trap and refusal checks
  // ------------------------------------------------------------------
  // A refused access must leave the control word alone
  mon_ctrl_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_ctrl && req.el == vci_pkg::EL3 && !cfg.sysreg_enable_monitor
    |=> rsp.trap_el3 && !rsp.trap_el2 && $stable(ctrl))
    else $error("EL3 control access not trapped");
  hyp_type_trap_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && !req.write && req.el == vci_pkg::EL2 && !cfg.sysreg_enable_hyp
    |=> rsp.trap_el2 && rsp.rdata == '0)
    else $error("EL2 type read not trapped");
  type_write_undef_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && req.write
    |=> rsp.undef && !rsp.trap_el2 && !rsp.trap_el3 && $stable(ctrl))
    else $error("type register write not refused");
  one_outcome_a: assert property (@(posedge clk_sys) disable iff (srst)
    $onehot0({rsp.trap_el2, rsp.trap_el3, rsp.undef, rsp.mem_redirect}))
    else $error("more than one access outcome");
  // Refused answers carry no data, so a core never takes a stale word
  trap_clean_a: assert property (@(posedge clk_sys) disable iff (srst)
    rsp.trap_el2 || rsp.trap_el3 || rsp.undef
    |-> rsp.rdata == '0 && rsp.mem_addr == '0)
    else $error("refused access carries data");
  secure_undef_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_ctrl && req.el == vci_pkg::EL2 && cfg.sysreg_enable_hyp && !sec_ok
    |=> rsp.undef)
    else $error("EL2 access without EL2 state accepted");
  el1_plain_undef_a: assert property (@(posedge clk_sys) disable iff (srst)
    (hit_ctrl || hit_type) && req.el == vci_pkg::EL1 && !cfg.nested_virt_ctrl
    |=> rsp.undef)
    else $error("plain EL1 access accepted");

  // ------------------------------------------------------------------
  // Redirect checks
  // ------------------------------------------------------------------
  redirect_full_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_ctrl && req.el == vci_pkg::EL1 && sec_ok && cfg.nested_virt_ctrl &&
    cfg.nested_virt_mem_redirect && !cfg.host_trap_general
    |=> rsp.mem_redirect && rsp.mem_addr ==
        ({12'h000, $past(cfg.nested_ctx_base)} << vci_pkg::PAGE_SHIFT) +
        vci_pkg::CTRL_MEM_OFS)
    else $error("nested access not redirected");
  // The core does the memory access; the register itself must not move
  redirect_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    rsp.mem_redirect |-> $stable(ctrl) && rsp.rdata == '0)
    else $error("redirected access touched control");

  // ------------------------------------------------------------------
  // Control data checks
  // ------------------------------------------------------------------
  ctrl_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_ctrl && !req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> rsp.rdata == $past(ctrl) && !rsp.undef)
    else $error("control read data wrong");
  ctrl_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    !(hit_ctrl && req.write) |=> $stable(ctrl))
    else $error("control changed without write");
  resv_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ctrl & ~vci_pkg::CTRL_WMASK) == '0)
    else $error("reserved control bit set");
  quiet_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
    !(hit_ctrl || hit_type) |=> rsp == '0)
    else $error("answer without access");
  done_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_ctrl || hit_type |=> rsp.done)
    else $error("access not answered");
  grp0_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_ctrl && req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> !HYP_IMPL || virt_grp0_enable == $past(req.wdata[vci_pkg::GRP0_EN_BIT]))
    else $error("group 0 enable not written");
  bpr_out_a: assert property (@(posedge clk_sys) disable iff (srst)
    virt_grp0_binary_point == ctrl[vci_pkg::BPR0_LSB +: 3])
    else $error("binary point output mismatch");
  // Low binary point writes saturate instead of being refused
  bpr_clamp_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_ctrl && req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor &&
    req.wdata[vci_pkg::BPR0_LSB +: 3] < vci_pkg::BPR_MAX - PREEMPT_M1
    |=> !HYP_IMPL || ctrl[vci_pkg::BPR0_LSB +: 3] == vci_pkg::BPR_MAX - PREEMPT_M1)
    else $error("binary point not clamped");

  // ------------------------------------------------------------------
  // Type register checks
  // ------------------------------------------------------------------
  mon_type_ok_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && !req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> rsp.rdata == TYPE_VALUE && !rsp.undef)
    else $error("EL3 type read wrong");
  hyp_type_ok_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && !req.write && req.el == vci_pkg::EL2 && cfg.sysreg_enable_hyp && sec_ok
    |=> rsp.rdata == TYPE_VALUE && !rsp.undef)
    else $error("EL2 type read wrong");
  no_hyp_type_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && !req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> HYP_IMPL || rsp.rdata == (64'h1 << vci_pkg::NOINJ_BIT))
    else $error("type word without EL2 wrong");
  type_fields_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && !req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> !HYP_IMPL || (rsp.rdata[vci_pkg::PRE_LSB +: 3] <= rsp.rdata[vci_pkg::PRIO_LSB +: 3] &&
        rsp.rdata[vci_pkg::PRE_LSB +: 3] >= vci_pkg::PRE_MIN_M1 &&
        rsp.rdata[vci_pkg::PRE_LSB +: 3] <= vci_pkg::PRE_MAX_M1))
    else $error("preemption field out of range");
  id_code_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && !req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> !HYP_IMPL || rsp.rdata[vci_pkg::ID_LSB +: 3] == vci_pkg::ID_16 ||
        rsp.rdata[vci_pkg::ID_LSB +: 3] == vci_pkg::ID_24)
    else $error("identifier width code reserved");
  lr_field_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && !req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> !HYP_IMPL || rsp.rdata[vci_pkg::LR_LSB +: 5] == LIST_REGS_M1)
    else $error("list register count wrong");
  resv_type_a: assert property (@(posedge clk_sys) disable iff (srst)
    hit_type && !req.write && req.el == vci_pkg::EL3 && cfg.sysreg_enable_monitor
    |=> rsp.rdata[63:32] == '0 && rsp.rdata[18:5] == '0)
    else $error("reserved type bit set");

  // ------------------------------------------------------------------
  // Scenario covers
  // ------------------------------------------------------------------
  cov_redirect_c: cover property (@(posedge clk_sys) rsp.mem_redirect);
  cov_trap_c: cover property (@(posedge clk_sys) rsp.trap_el2);
  cov_type_c: cover property (@(posedge clk_sys) rsp.done && rsp.rdata == TYPE_VALUE);
  cov_grp0_c: cover property (@(posedge clk_sys) $rose(virt_grp0_enable));
endmodule
`default_nettype wire
